// ### rtl/flag_command_device.sv
// device end: flag decoding, block receive, parse, execute, response
`default_nettype none
module flag_command_device
  import flag_engine_pkg::*;
#(
  parameter logic [7:0] READ_OPCODE      = 8'h02,
  parameter logic [7:0] WRITE_OPCODE     = 8'h12,
  parameter logic [7:0] LOCK_OPCODE      = 8'h13,
  parameter logic [7:0] FUSE_OPCODE      = 8'h14,
  parameter logic [7:0] LOAD_OPCODE      = 8'h15,
  parameter logic [7:0] PERSON_OPCODE    = 8'h16,
  parameter logic [7:0] AUTH_OPCODE      = 8'h08,
  parameter int MEMORY_LIMIT_CYCLES      = MEMORY_COMMAND_CYCLES,
  parameter int FUSE_LIMIT_CYCLES        = FUSE_PROGRAM_CYCLES,
  parameter int AUTH_LIMIT_CYCLES        = AUTHENTICATION_COMPUTE_CYCLES,
  parameter int PERSON_LIMIT_CYCLES      = PERSONALIZATION_CYCLES
) (
  input  wire logic                 clk_sys_in,
  input  wire logic                 reset_in,
  input  wire logic                 ce_in,
  flag_link_if.device_mp            link,
  output var  logic                 cmd_start_out,
  output var  flag_engine_pkg::exec_class_type cmd_class_out,
  output var  logic [7:0]           cmd_opcode_out,
  output var  logic [7:0]           cmd_param_out,
  input  wire logic                 exec_done_in,
  input  wire logic                 exec_error_in,
  input  wire logic [7:0]           exec_result_in,
  output logic                      awake_out,
  output logic                      busy_out
);
  import flag_engine_pkg::*;

  typedef enum logic [2:0] {
    ST_SLEEP = 3'b000,
    ST_IDLE  = 3'b001,
    ST_RX    = 3'b010,
    ST_EXEC  = 3'b011,
    ST_TURN  = 3'b100,
    ST_TX    = 3'b101
  } dev_state_type;

  typedef struct packed {
    dev_state_type        state;
    logic [7:0]           idx;
    logic [7:0]           count;
    logic [15:0]          crc;
    logic [7:0]           crc_lo;
    logic [7:0]           opcode;
    logic [7:0]           param;
    logic [7:0]           resp_code;
    logic [TIMER_W-1:0]   timer;
    logic [TIMER_W-1:0]   limit;
    exec_class_type       cls;
    logic                 start;
    logic                 d2h_stb;
    logic [7:0]           d2h_data;
  } dev_type;

  localparam dev_type DEV_RESET = '{
    state: ST_SLEEP, idx: 8'h00, count: 8'h00, crc: CRC_INIT,
    crc_lo: 8'h00, opcode: 8'h00, param: 8'h00, resp_code: STATUS_WAKE,
    timer: '0, limit: '0, cls: EXEC_NONE, start: 1'b0,
    d2h_stb: 1'b0, d2h_data: 8'h00};

  dev_type dev_reg;
  dev_type dev_next;

  function automatic exec_class_type class_of(input logic [7:0] op);
    if (op == READ_OPCODE || op == WRITE_OPCODE || op == LOCK_OPCODE)
      return EXEC_MEMORY;
    else if (op == FUSE_OPCODE)
      return EXEC_FUSE;
    else if (op == AUTH_OPCODE)
      return EXEC_AUTH;
    else if (op == PERSON_OPCODE || op == LOAD_OPCODE)
      return EXEC_PERSON;
    else
      return EXEC_NONE;
  endfunction : class_of

  function automatic logic [TIMER_W-1:0] limit_of(input exec_class_type c);
    unique case (c)
      EXEC_MEMORY: return TIMER_W'(MEMORY_LIMIT_CYCLES);
      EXEC_FUSE:   return TIMER_W'(FUSE_LIMIT_CYCLES);
      EXEC_AUTH:   return TIMER_W'(AUTH_LIMIT_CYCLES);
      EXEC_PERSON: return TIMER_W'(PERSON_LIMIT_CYCLES);
      default:     return '0;
    endcase
  endfunction : limit_of

  logic [15:0] resp_crc;
  assign resp_crc = crc16_update(crc16_update(CRC_INIT, STATUS_BLOCK_COUNT),
                                 dev_reg.resp_code);

  always_comb
  begin
    dev_next         = dev_reg;
    dev_next.start   = 1'b0;
    dev_next.d2h_stb = 1'b0;
    unique case (dev_reg.state)
      ST_SLEEP:
      begin
        if (link.wake_stb)
        begin
          dev_next           = DEV_RESET;
          dev_next.state     = ST_IDLE;
          dev_next.resp_code = STATUS_WAKE;
        end
      end
      ST_IDLE:
      begin
        if (link.h2d_stb)
        begin
          if (link.h2d_data == FLAG_COMMAND)
          begin
            dev_next.state = ST_RX;
            dev_next.idx   = 8'h00;
            dev_next.crc   = CRC_INIT;
          end
          else if (link.h2d_data == FLAG_TRANSMIT)
          begin
            dev_next.state = ST_TURN;
            dev_next.timer = '0;
          end
          else if (link.h2d_data == FLAG_SLEEP)
            dev_next = DEV_RESET;
          // reserved flags fall through untouched
        end
      end
      ST_RX:
      begin
        if (link.h2d_stb)
        begin
          dev_next.idx = 8'(dev_reg.idx + 8'h01);
          if (dev_reg.idx < 8'(dev_reg.count - CRC_BYTES) ||
              dev_reg.idx == 8'h00)
            dev_next.crc = crc16_update(dev_reg.crc, link.h2d_data);
          if (dev_reg.idx == 8'h00)
          begin
            dev_next.count = link.h2d_data;
            // bad count aborts at once; trailing bytes read as flags
            if (link.h2d_data < COUNT_MIN || link.h2d_data > COUNT_MAX)
            begin
              dev_next.state     = ST_IDLE;
              dev_next.resp_code = STATUS_PARSE_ERROR;
            end
          end
          if (dev_reg.idx == IDX_OPCODE)
            dev_next.opcode = link.h2d_data;
          if (dev_reg.idx == IDX_PARAM)
            dev_next.param = link.h2d_data;
          if (dev_reg.idx == 8'(dev_reg.count - CRC_BYTES))
            dev_next.crc_lo = link.h2d_data;
          if (dev_reg.idx != 8'h00 &&
              dev_reg.idx == 8'(dev_reg.count - 8'h01))
          begin
            // parse finishes in this one cycle, well inside the limit
            if ({link.h2d_data, dev_reg.crc_lo} != dev_reg.crc ||
                class_of(dev_reg.opcode) == EXEC_NONE)
            begin
              dev_next.state     = ST_IDLE;
              dev_next.resp_code = STATUS_PARSE_ERROR;
            end
            else
            begin
              dev_next.state = ST_EXEC;
              dev_next.cls   = class_of(dev_reg.opcode);
              dev_next.limit = limit_of(class_of(dev_reg.opcode));
              dev_next.timer = '0;
              dev_next.start = 1'b1;
            end
          end
        end
      end
      ST_EXEC:
      begin
        // link strobes are not looked at here
        dev_next.timer = TIMER_W'(dev_reg.timer + 1'b1);
        if (exec_done_in)
        begin
          dev_next.state     = ST_IDLE;
          dev_next.resp_code = exec_error_in ? STATUS_EXEC_ERROR
                                             : exec_result_in;
        end
        else if (dev_reg.timer >= TIMER_W'(dev_reg.limit - 1'b1))
        begin
          // an overrunning executor is cut off to keep the bound
          dev_next.state     = ST_IDLE;
          dev_next.resp_code = STATUS_EXEC_ERROR;
        end
      end
      ST_TURN:
      begin
        dev_next.timer = TIMER_W'(dev_reg.timer + 1'b1);
        if (dev_reg.timer >= TIMER_W'(LINE_TURNAROUND_CYCLES - 1))
        begin
          dev_next.state = ST_TX;
          dev_next.idx   = 8'h00;
        end
      end
      ST_TX:
      begin
        dev_next.d2h_stb = 1'b1;
        dev_next.idx     = 8'(dev_reg.idx + 8'h01);
        // resp_code is untouched here so a repeat poll matches
        unique case (dev_reg.idx)
          8'h00:      dev_next.d2h_data = STATUS_BLOCK_COUNT;
          IDX_OPCODE: dev_next.d2h_data = dev_reg.resp_code;
          IDX_CRC_LO: dev_next.d2h_data = resp_crc[7:0];
          default:    dev_next.d2h_data = resp_crc[15:8];
        endcase
        if (dev_reg.idx == IDX_CRC_HI)
          dev_next.state = ST_IDLE;
      end
      default:
        dev_next = DEV_RESET;
    endcase
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
      dev_reg <= DEV_RESET;
    else if (ce_in)
      dev_reg <= dev_next;
  end

  assign link.d2h_stb  = dev_reg.d2h_stb;
  assign link.d2h_data = dev_reg.d2h_data;
  assign cmd_start_out  = dev_reg.start;
  assign cmd_class_out  = dev_reg.cls;
  assign cmd_opcode_out = dev_reg.opcode;
  assign cmd_param_out  = dev_reg.param;
  assign awake_out      = dev_reg.state != ST_SLEEP;
  assign busy_out       = dev_reg.state == ST_EXEC;
endmodule : flag_command_device
`default_nettype wire

// ### rtl/flag_command_host.sv
// host end: command byte fifo, flag sender, response receiver
`default_nettype none
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic             clk_sys_in,
  input  wire logic             reset_in,
  input  wire logic             ce_in,
  input  wire logic             in_valid_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  in_ready_out,
  output logic                  out_valid_out,
  output logic [WIDTH-1:0]      out_data_out,
  input  wire logic             out_ready_in
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW:0] wr;
    logic [AW:0] rd;
  } ptr_type;

  ptr_type          ptr_reg;
  ptr_type          ptr_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             full;
  logic             empty;
  logic             push;
  logic             pop;

  assign empty = ptr_reg.wr == ptr_reg.rd;
  assign full  = ptr_reg.wr == {~ptr_reg.rd[AW], ptr_reg.rd[AW-1:0]};
  assign in_ready_out  = !full;
  assign out_valid_out = !empty;
  assign out_data_out  = mem[ptr_reg.rd[AW-1:0]];
  assign push = in_valid_in && !full;
  assign pop  = out_ready_in && !empty;

  always_comb
  begin
    ptr_next = ptr_reg;
    if (push)
      ptr_next.wr = (AW+1)'(ptr_reg.wr + 1'b1);
    if (pop)
      ptr_next.rd = (AW+1)'(ptr_reg.rd + 1'b1);
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
      ptr_reg <= '0;
    else if (ce_in)
    begin
      ptr_reg <= ptr_next;
      if (push)
        mem[ptr_reg.wr[AW-1:0]] <= in_data_in;
    end
  end
endmodule : byte_fifo

module flag_command_host
  import flag_engine_pkg::*;
(
  input  wire logic                 clk_sys_in,
  input  wire logic                 reset_in,
  input  wire logic                 ce_in,
  flag_link_if.host_mp              link,
  input  wire logic                 op_valid_in,
  input  wire flag_engine_pkg::host_op_type op_code_in,
  output logic                      op_ready_out,
  input  wire logic                 cmd_valid_in,
  input  wire logic [7:0]           cmd_data_in,
  output logic                      cmd_ready_out,
  output logic                      resp_valid_out,
  output logic [7:0]                resp_data_out,
  output logic                      done_out,
  output logic                      crc_ok_out,
  output logic                      timeout_out
);
  import flag_engine_pkg::*;

  typedef enum logic [2:0] {
    H_IDLE   = 3'b000,
    H_SEND   = 3'b001,
    H_CRC_LO = 3'b010,
    H_CRC_HI = 3'b011,
    H_WAIT   = 3'b100,
    H_RECV   = 3'b101
  } host_state_type;

  typedef struct packed {
    host_state_type          state;
    logic [7:0]              idx;
    logic [7:0]              count;
    logic [15:0]             crc;
    logic [7:0]              crc_lo;
    logic [HOST_TIMER_W-1:0] timer;
    logic                    wake;
    logic                    h2d_stb;
    logic [7:0]              h2d_data;
    logic                    resp_valid;
    logic [7:0]              resp_data;
    logic                    done;
    logic                    crc_ok;
    logic                    timeout;
  } host_type;

  localparam host_type HOST_RESET = '{
    state: H_IDLE, idx: 8'h00, count: 8'h00, crc: CRC_INIT, crc_lo: 8'h00,
    timer: '0, wake: 1'b0, h2d_stb: 1'b0, h2d_data: 8'h00,
    resp_valid: 1'b0, resp_data: 8'h00, done: 1'b0, crc_ok: 1'b0,
    timeout: 1'b0};

  host_type   host_reg;
  host_type   host_next;
  logic       fifo_valid;
  logic [7:0] fifo_data;
  logic       fifo_pop;

  // stalls on an empty fifo, so the user may trickle bytes in
  assign fifo_pop = ce_in && host_reg.state == H_SEND && fifo_valid;

  byte_fifo #(
    .WIDTH (8),
    .DEPTH (32)
  ) cmd_fifo (
    .clk_sys_in    (clk_sys_in),
    .reset_in      (reset_in),
    .ce_in         (ce_in),
    .in_valid_in   (cmd_valid_in),
    .in_data_in    (cmd_data_in),
    .in_ready_out  (cmd_ready_out),
    .out_valid_out (fifo_valid),
    .out_data_out  (fifo_data),
    .out_ready_in  (fifo_pop)
  );

  always_comb
  begin
    host_next            = host_reg;
    host_next.wake       = 1'b0;
    host_next.h2d_stb    = 1'b0;
    host_next.resp_valid = 1'b0;
    host_next.done       = 1'b0;
    unique case (host_reg.state)
      H_IDLE:
      begin
        if (op_valid_in)
        begin
          host_next.crc     = CRC_INIT;
          host_next.idx     = 8'h00;
          host_next.timer   = '0;
          host_next.h2d_stb = op_code_in != OP_WAKE;
          host_next.wake    = op_code_in == OP_WAKE;
          unique case (op_code_in)
            OP_WAKE:     host_next.h2d_data = host_reg.h2d_data;
            OP_COMMAND:
            begin
              host_next.h2d_data = FLAG_COMMAND;
              host_next.state    = H_SEND;
            end
            OP_TRANSMIT:
            begin
              host_next.h2d_data = FLAG_TRANSMIT;
              host_next.state    = H_WAIT;
            end
            OP_SLEEP:    host_next.h2d_data = FLAG_SLEEP;
          endcase
        end
      end
      H_SEND:
      begin
        if (fifo_valid)
        begin
          host_next.h2d_stb  = 1'b1;
          host_next.h2d_data = fifo_data;
          host_next.crc      = crc16_update(host_reg.crc, fifo_data);
          host_next.idx      = 8'(host_reg.idx + 8'h01);
          if (host_reg.idx == 8'h00)
            host_next.count = fifo_data;
          if ((host_reg.idx == 8'h00 && fifo_data <= CRC_BYTES + 8'h01) ||
              (host_reg.idx != 8'h00 &&
               host_reg.idx == 8'(host_reg.count - CRC_BYTES - 8'h01)))
            host_next.state = H_CRC_LO;
        end
      end
      H_CRC_LO:
      begin
        host_next.h2d_stb  = 1'b1;
        host_next.h2d_data = host_reg.crc[7:0];
        host_next.state    = H_CRC_HI;
      end
      H_CRC_HI:
      begin
        host_next.h2d_stb  = 1'b1;
        host_next.h2d_data = host_reg.crc[15:8];
        host_next.state    = H_IDLE;
        host_next.done     = 1'b1;
        host_next.crc_ok   = 1'b1;
        host_next.timeout  = 1'b0;
      end
      H_WAIT, H_RECV:
      begin
        host_next.timer = HOST_TIMER_W'(host_reg.timer + 1'b1);
        if (link.d2h_stb)
        begin
          host_next.timer      = '0;
          host_next.state      = H_RECV;
          host_next.resp_valid = 1'b1;
          host_next.resp_data  = link.d2h_data;
          host_next.idx        = 8'(host_reg.idx + 8'h01);
          if (host_reg.idx == 8'h00)
            host_next.count = link.d2h_data;
          if (host_reg.idx == 8'h00 ||
              host_reg.idx < 8'(host_reg.count - CRC_BYTES))
            host_next.crc = crc16_update(host_reg.crc, link.d2h_data);
          if (host_reg.idx == 8'(host_reg.count - CRC_BYTES))
            host_next.crc_lo = link.d2h_data;
          if (host_reg.idx != 8'h00 &&
              host_reg.idx == 8'(host_reg.count - 8'h01))
          begin
            host_next.state   = H_IDLE;
            host_next.done    = 1'b1;
            host_next.timeout = 1'b0;
            host_next.crc_ok  =
              {link.d2h_data, host_reg.crc_lo} == host_reg.crc;
          end
        end
        else if (host_reg.timer >=
                 HOST_TIMER_W'(RESPONSE_TIMEOUT_CYCLES - 1))
        begin
          // silence means busy device or lost sync
          host_next.state   = H_IDLE;
          host_next.done    = 1'b1;
          host_next.timeout = 1'b1;
          host_next.crc_ok  = 1'b0;
        end
      end
      default:
        host_next = HOST_RESET;
    endcase
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
      host_reg <= HOST_RESET;
    else if (ce_in)
      host_reg <= host_next;
  end

  assign link.wake_stb = host_reg.wake;
  assign link.h2d_stb  = host_reg.h2d_stb;
  assign link.h2d_data = host_reg.h2d_data;
  assign op_ready_out   = host_reg.state == H_IDLE;
  assign resp_valid_out = host_reg.resp_valid;
  assign resp_data_out  = host_reg.resp_data;
  assign done_out       = host_reg.done;
  assign crc_ok_out     = host_reg.crc_ok;
  assign timeout_out    = host_reg.timeout;
endmodule : flag_command_host
`default_nettype wire

// ### rtl/flag_engine_pkg.sv
// shared constants, types and checksum for the single-wire flag link
`default_nettype none
package flag_engine_pkg;
  localparam logic [7:0] FLAG_COMMAND       = 8'h77;
  localparam logic [7:0] FLAG_TRANSMIT      = 8'h88;
  localparam logic [7:0] FLAG_SLEEP         = 8'hcc;
  localparam logic [7:0] STATUS_WAKE        = 8'h11;
  localparam logic [7:0] STATUS_SUCCESS     = 8'h00;
  localparam logic [7:0] STATUS_EXEC_ERROR  = 8'h0f;
  localparam logic [7:0] STATUS_PARSE_ERROR = 8'hff;
  localparam logic [7:0] COUNT_MIN          = 8'h04;
  localparam logic [7:0] COUNT_MAX          = 8'h27;
  localparam logic [7:0] STATUS_BLOCK_COUNT = 8'h04;
  localparam logic [7:0] CRC_BYTES          = 8'h02;
  localparam logic [7:0] IDX_OPCODE         = 8'h01;
  localparam logic [7:0] IDX_PARAM          = 8'h02;
  localparam logic [7:0] IDX_CRC_LO         = 8'h02;
  localparam logic [7:0] IDX_CRC_HI         = 8'h03;
  localparam logic [15:0] CRC_POLY          = 16'h8005;
  localparam logic [15:0] CRC_INIT          = 16'h0000;
  localparam int TIMER_W                    = 20;
  localparam int HOST_TIMER_W               = 12;
  localparam int CLK_HZ                     = 25_000_000;
  localparam int US_PER_S                   = 1_000_000;
  localparam int MS_PER_S                   = 1_000;
  localparam int PARSE_DELAY_US             = 100;
  localparam int MEMORY_COMMAND_DELAY_MS    = 3;
  localparam int FUSE_PROGRAM_DELAY_US      = 700;
  localparam int AUTHENTICATION_COMPUTE_DELAY_MS = 30;
  localparam int PERSONALIZATION_DELAY_MS   = 13;
  localparam int TURNAROUND_MIN_US          = 28;
  localparam int TURNAROUND_MAX_US          = 95;
  localparam int PARSE_DELAY_CYCLES = PARSE_DELAY_US * (CLK_HZ / US_PER_S);
  localparam int MEMORY_COMMAND_CYCLES =
    MEMORY_COMMAND_DELAY_MS * (CLK_HZ / MS_PER_S);
  localparam int FUSE_PROGRAM_CYCLES =
    FUSE_PROGRAM_DELAY_US * (CLK_HZ / US_PER_S);
  localparam int AUTHENTICATION_COMPUTE_CYCLES =
    AUTHENTICATION_COMPUTE_DELAY_MS * (CLK_HZ / MS_PER_S);
  localparam int PERSONALIZATION_CYCLES =
    PERSONALIZATION_DELAY_MS * (CLK_HZ / MS_PER_S);
  localparam int LINE_TURNAROUND_CYCLES =
    (TURNAROUND_MIN_US * CLK_HZ + US_PER_S - 1) / US_PER_S;
  // cycles per microsecond first: the plain product overflows an int
  localparam int RESPONSE_TIMEOUT_CYCLES =
    TURNAROUND_MAX_US * (CLK_HZ / US_PER_S);

  typedef enum logic [2:0] {
    EXEC_NONE   = 3'b000,
    EXEC_MEMORY = 3'b001,
    EXEC_FUSE   = 3'b010,
    EXEC_AUTH   = 3'b011,
    EXEC_PERSON = 3'b100
  } exec_class_type;

  typedef enum logic [1:0] {
    OP_WAKE     = 2'b00,
    OP_COMMAND  = 2'b01,
    OP_TRANSMIT = 2'b10,
    OP_SLEEP    = 2'b11
  } host_op_type;

  // bits enter lsb first, as on the wire
  function automatic logic [15:0] crc16_update(input logic [15:0] crc,
                                               input logic [7:0]  data);
    logic [15:0] c;
    logic        fb;
    c = crc;
    for (int i = 0; i < 8; i++)
    begin
      fb = c[15] ^ data[i];
      c  = {c[14:0], 1'b0};
      if (fb)
        c = c ^ CRC_POLY;
    end
    return c;
  endfunction : crc16_update
endpackage : flag_engine_pkg
`default_nettype wire

// ### rtl/flag_link_if.sv
// byte-level single-wire link between host and device
`default_nettype none
interface flag_link_if (
  input wire logic clk_sys_in
);
  logic       wake_stb;
  logic       h2d_stb;
  logic [7:0] h2d_data;
  logic       d2h_stb;
  logic [7:0] d2h_data;

  modport device_mp (
    input  wake_stb,
    input  h2d_stb,
    input  h2d_data,
    output d2h_stb,
    output d2h_data
  );
  modport host_mp (
    output wake_stb,
    output h2d_stb,
    output h2d_data,
    input  d2h_stb,
    input  d2h_data
  );
endinterface : flag_link_if
`default_nettype wire

// ### verif/flag_link_sva.sv
// link checker for the flag command engine
`default_nettype none
module flag_link_sva (
  input wire logic       clk_sys_in,
  input wire logic       reset_in,
  input wire logic       wake_stb,
  input wire logic       h2d_stb,
  input wire logic [7:0] h2d_data,
  input wire logic       d2h_stb,
  input wire logic [7:0] d2h_data
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys_in);
  endclocking
  default disable iff (reset_in);
  a_resp_count_first: assert property (
    $rose(d2h_stb) |-> d2h_data == 8'h04) else $error("bad count byte");
  a_resp_four_bytes: assert property (
    $rose(d2h_stb) |-> d2h_stb [*4] ##1 !d2h_stb) else $error("bad length");
  a_turn_wait: assert property (
    $rose(d2h_stb) |-> ($past(h2d_stb, 701) && $past(h2d_data, 701) == 8'h88)
    || ($past(h2d_stb, 702) && $past(h2d_data, 702) == 8'h88))
    else $error("response not after transmit flag");
  a_turn_quiet: assert property (
    h2d_stb && h2d_data == 8'h88 && !d2h_stb |=> !d2h_stb [*8])
    else $error("response too early");
  a_wake_quiet: assert property (
    wake_stb |=> !d2h_stb [*8]) else $error("response after wake");
  a_host_quiet: assert property (
    d2h_stb |-> !h2d_stb && !wake_stb) else $error("host talks over reply");
  a_wake_alone: assert property (
    wake_stb |-> !h2d_stb) else $error("wake with byte");
  a_code_legal: assert property (
    $rose(d2h_stb) |=> d2h_data inside {8'h11, 8'h00, 8'h0f, 8'hff})
    else $error("unknown status code");
endmodule : flag_link_sva
`default_nettype wire

// ### verif/tb.sv
// testbench: host and device joined over the flag link
`default_nettype none
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin \
  n_fail++; $display("ERROR %s expected %h seen %h", n, e, a); end end
module tb;
  import flag_engine_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic           clk_sys_in = 1'b0;
  logic           reset_in = 1'b1;
  logic           op_valid_in = 1'b0;
  host_op_type    op_code_in = OP_WAKE;
  logic           cmd_valid_in = 1'b0;
  logic [7:0]     cmd_data_in = 8'h00;
  logic           exec_done_in = 1'b0;
  logic           silent = 1'b0;
  logic [3:0]     pend = 4'd0;
  logic           op_ready_out, cmd_ready_out, resp_valid_out, done_out;
  logic           crc_ok_out, timeout_out, cmd_start_out;
  logic           awake_out, busy_out;
  logic           exec_err = 1'b0;
  logic [7:0]     resp_data_out, cmd_opcode_out, cmd_param_out;
  exec_class_type cmd_class_out;
  logic [7:0]     rq[$];
  int             n_fail = 0;
  int             total_checks = 0;
  int             cyc = 0;
  logic [7:0]     ops[7] = '{8'h02, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h08};
  exec_class_type cls[7] = '{EXEC_MEMORY, EXEC_MEMORY, EXEC_MEMORY,
    EXEC_FUSE, EXEC_PERSON, EXEC_PERSON, EXEC_AUTH};
  always #20 clk_sys_in = ~clk_sys_in;
  flag_link_if lnk (.clk_sys_in(clk_sys_in));
  // short exec limits keep overrun cases quick
  flag_command_device #(.MEMORY_LIMIT_CYCLES(50), .FUSE_LIMIT_CYCLES(50),
    .AUTH_LIMIT_CYCLES(50), .PERSON_LIMIT_CYCLES(50)) flag_command_device_i (
    .clk_sys_in(clk_sys_in), .reset_in(reset_in), .ce_in(1'b1), .link(lnk),
    .cmd_start_out(cmd_start_out), .cmd_class_out(cmd_class_out),
    .cmd_opcode_out(cmd_opcode_out), .cmd_param_out(cmd_param_out),
    .exec_done_in(exec_done_in), .exec_error_in(exec_err),
    .exec_result_in(8'h00), .awake_out(awake_out), .busy_out(busy_out));
  flag_command_host flag_command_host_i (
    .clk_sys_in(clk_sys_in), .reset_in(reset_in), .ce_in(1'b1), .link(lnk),
    .op_valid_in(op_valid_in), .op_code_in(op_code_in),
    .op_ready_out(op_ready_out), .cmd_valid_in(cmd_valid_in),
    .cmd_data_in(cmd_data_in), .cmd_ready_out(cmd_ready_out),
    .resp_valid_out(resp_valid_out), .resp_data_out(resp_data_out),
    .done_out(done_out), .crc_ok_out(crc_ok_out), .timeout_out(timeout_out));
  flag_link_sva flag_link_sva_i (
    .clk_sys_in(clk_sys_in), .reset_in(reset_in), .wake_stb(lnk.wake_stb),
    .h2d_stb(lnk.h2d_stb), .h2d_data(lnk.h2d_data),
    .d2h_stb(lnk.d2h_stb), .d2h_data(lnk.d2h_data));
  task automatic test_done;
    $display("checks %0d errors %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : test_done
  // executor stand-in; silent mode forces an overrun
  always @(posedge clk_sys_in)
  begin
    cyc <= cyc + 1;
    if (resp_valid_out)
      rq.push_back(resp_data_out);
    exec_done_in <= 1'b0;
    if (cmd_start_out && !silent)
      pend <= 4'd5;
    else if (pend != 4'd0)
    begin
      pend <= pend - 4'd1;
      exec_done_in <= (pend == 4'd1);
    end
    if (cyc == 40000)
    begin
      n_fail++;
      test_done();
    end
  end
  function automatic logic [15:0] crc2(input logic [7:0] a, input logic [7:0] b);
    logic [15:0] c;
    logic [15:0] d;
    c = 16'h0000;
    d = {b, a};
    for (int i = 0; i < 16; i++)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h8005 : 16'h0000);
    return c;
  endfunction : crc2
  task automatic op(input host_op_type c);
    while (op_ready_out !== 1'b1)
      @(posedge clk_sys_in);
    @(posedge clk_sys_in);
    op_valid_in <= 1'b1;
    op_code_in <= c;
    @(posedge clk_sys_in);
    op_valid_in <= 1'b0;
  endtask : op
  task automatic wait_done;
    for (int i = 0; i < 4000 && done_out !== 1'b1; i++)
      @(posedge clk_sys_in);
  endtask : wait_done
  // four-byte block or a lone short count; host appends the checksum
  task automatic cmd(input logic [7:0] opc, input logic [7:0] cnt = 8'h04);
    @(posedge clk_sys_in);
    cmd_valid_in <= 1'b1;
    cmd_data_in <= cnt;
    if (cnt > 8'h03)
    begin
      @(posedge clk_sys_in);
      cmd_data_in <= opc;
    end
    @(posedge clk_sys_in);
    cmd_valid_in <= 1'b0;
    op(OP_COMMAND);
    wait_done();
    repeat (20) @(posedge clk_sys_in);
  endtask : cmd
  task automatic xfer(input logic [7:0] code, input logic ok);
    rq.delete();
    op(OP_TRANSMIT);
    wait_done();
    @(posedge clk_sys_in);
    if (ok)
    begin
      `CHK("resp_len", 4, rq.size())
      `CHK("resp_count", 8'h04, rq[0])
      `CHK("resp_code", code, rq[1])
      `CHK("resp_crc", crc2(8'h04, code), {rq[3], rq[2]})
      `CHK("crc_ok", 1'b1, crc_ok_out)
    end
    else
      `CHK("timeout", 1'b1, timeout_out)
  endtask : xfer
  initial
  begin
    repeat (5) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    @(posedge clk_sys_in);
    `CHK("awake", 1'b0, awake_out)
    op(OP_WAKE);
    xfer(STATUS_WAKE, 1'b1);
    `CHK("awake", 1'b1, awake_out)
    for (int i = 0; i < 7; i++)
    begin
      cmd(ops[i]);
      `CHK("class", cls[i], cmd_class_out)
      `CHK("opcode", ops[i], cmd_opcode_out)
      `CHK("param", 8'(crc2(8'h04, ops[i])), cmd_param_out)
      xfer(STATUS_SUCCESS, 1'b1);
    end
    xfer(STATUS_SUCCESS, 1'b1);
    cmd(8'h55);
    xfer(STATUS_PARSE_ERROR, 1'b1);
    exec_err <= 1'b1;
    cmd(8'h02);
    xfer(STATUS_EXEC_ERROR, 1'b1);
    exec_err <= 1'b0;
    // checksum bytes of a short block land as reserved flags
    cmd(8'h00, 8'h03);
    xfer(STATUS_PARSE_ERROR, 1'b1);
    silent <= 1'b1;
    cmd(8'h08);
    `CHK("busy", 1'b1, busy_out)
    xfer(8'h00, 1'b0);
    silent <= 1'b0;
    xfer(STATUS_EXEC_ERROR, 1'b1);
    op(OP_SLEEP);
    xfer(8'h00, 1'b0);
    `CHK("awake", 1'b0, awake_out)
    op(OP_WAKE);
    xfer(STATUS_WAKE, 1'b1);
    test_done();
  end
endmodule : tb
`undef CHK
`default_nettype wire
